// File: ufm_defs.vh
// Constants shared by the user file manager block
`ifndef UFM_DEFS_VH
`define UFM_DEFS_VH

// ==========================================================================
// Resource identifiers
`define UFM_RID_W          10
`define UFM_RID_MAINT      10'h133
`define UFM_RID_DIR        10'h134

// ==========================================================================
// Offset field positions
`define UFM_OP_HI          9
`define UFM_OP_LO          8
`define UFM_WR_HI          7
`define UFM_WR_LO          4
`define UFM_RD_HI          3
`define UFM_RD_LO          0
`define UFM_SEL_HI         7
`define UFM_SEL_LO         0

// ==========================================================================
// Operation codes in offset bits 9-8
`define UFM_OP_DELETE      2'h0
`define UFM_OP_CHANGE      2'h1
`define UFM_OP_CREATE      2'h3

// ==========================================================================
// Access rights
`define UFM_LVL_FORBID     4'hF
`define UFM_LVL_PUBLIC     4'h0

// ==========================================================================
// Name characters
`define UFM_CHR_NUL        8'h00
`define UFM_CHR_LO         8'h20
`define UFM_CHR_HI         8'h7E

// ==========================================================================
// Descriptor values and descriptor field selectors
`define UFM_DSC_NAME       8'h00
`define UFM_DSC_SIZE       8'h01
`define UFM_DSC_RDLVL      8'h02
`define UFM_DSC_WRLVL      8'h03
`define UFM_DSC_TMO        8'h04
`define UFM_DSC_TYPE       8'h05
`define UFM_DATA_SIZE      8'h08
`define UFM_MAINT_RDLVL    8'h0F
`define UFM_MAINT_WRLVL    8'h00
`define UFM_MAINT_TYPE     8'h0B
`define UFM_DIR_RDLVL      8'h00
`define UFM_DIR_WRLVL      8'h0F
`define UFM_DIR_TYPE       8'h18

// ==========================================================================
// Directory selector for the summary reply
`define UFM_DIR_SUMMARY    8'h00

// ==========================================================================
// Answer codes
`define UFM_ERR_NONE       8'h00
`define UFM_ERR_RID        8'h01
`define UFM_ERR_ACCESS     8'h02
`define UFM_ERR_OPCODE     8'h03
`define UFM_ERR_NAME       8'h04
`define UFM_ERR_EXISTS     8'h05
`define UFM_ERR_FULL       8'h06
`define UFM_ERR_NOT_LOADED 8'h07
`define UFM_ERR_MISMATCH   8'h08
`define UFM_ERR_NOT_FOUND  8'h09
`define UFM_ERR_DESC       8'h0A

`endif

// File: ufm_name_mem.v
// File name store: one 64-bit name per slot, registered read data
`timescale 1ns/1ps
`default_nettype none

module ufm_name_mem #(
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock
  input  wire          clk,
  // Write port
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [63:0]   wr_data,
  // Read port
  input  wire [AW-1:0] rd_addr,
  output reg  [63:0]   rd_data
);

  reg [63:0] mem_reg [0:DEPTH-1];

  // ========================================================================
  // Storage; no reset, slot validity lives in the control logic
  always @(posedge clk)
  begin
    if (wr_en)
    begin
      mem_reg[wr_addr] <= wr_data;
    end
    rd_data <= mem_reg[rd_addr];
  end

endmodule // ufm_name_mem

`default_nettype wire

// File: ufm_file_manager.v
// User file maintenance and directory command handler
// Function
// - A file must be created before it can be loaded, written or read.
// - Change and delete act only on the currently loaded file.
// - Creating a name that already exists is aborted with an error.
// - Names hold at least one character, all within 20h..7Eh.
// - Offset bits 9-8 pick create 11b, change 01b, delete 00b.
// - Delete uses code 00b, removes the loaded file, bits 7-0 reserved.
// - Offset bits 7-4 are write rights, bits 3-0 read rights.
// - Maintenance resource 133h: size 8, read level 15, type 0Bh.
// - Directory resource 134h: size 8, read 0, write 15, type 18h.
// - Directory lists only files accessible at the current level.
// - Directory offset 00h gives summary, n gives the nth file name.
// - Summary: count byte 0, empty bytes 3/2, filled bytes 5/4.
// - Directory offset above 00h returns the file name in bytes 7..0.
`timescale 1ns/1ps
`default_nettype none
`include "ufm_defs.vh"

module ufm_file_manager #(
  parameter MAX_FILES   = 16,
  parameter AW          = 4,
  parameter STORE_BYTES = 16'h2000,
  parameter HDR_BYTES   = 16'h0010,
  parameter TMO_VALUE   = 8'h10,
  parameter RES_NAME    = 64'h0
) (
  // Clock and reset
  input  wire          clk,
  input  wire          rst,
  // Transaction request, from logic on the same clock
  input  wire          parameter_transaction_trigger,
  input  wire          write_access,
  input  wire          descriptor_read,
  input  wire [7:0]    resource_select_high,
  input  wire [7:0]    resource_select_low,
  input  wire [7:0]    operation_offset_high,
  input  wire [7:0]    operation_offset_low,
  input  wire [63:0]   long_message_bytes,
  // Session state from the load and login logic
  input  wire [3:0]    access_level,
  input  wire          file_loaded,
  input  wire [AW-1:0] loaded_slot,
  // Answer
  output reg           parameter_access_done,
  output reg           busy,
  output reg           error_flag,
  output reg  [7:0]    error_code,
  output reg  [63:0]   reply_bytes,
  // File table status
  output reg           file_deleted,
  output reg  [MAX_FILES-1:0] file_valid,
  output reg  [7:0]    file_count
);

  // ========================================================================
  // State codes
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_RD   = 2'h1;
  localparam [1:0] S_CMP  = 2'h2;
  // Kept as an integer so the comparison widens idx_reg rather than cutting the count
  localparam integer LAST_SLOT = MAX_FILES - 1;

  reg  [1:0]      state_reg;
  reg  [AW-1:0]   idx_reg;
  reg  [AW-1:0]   free_reg;
  reg             free_found_reg;
  reg  [7:0]      hits_reg;
  reg  [1:0]      op_reg;
  reg             dir_reg;
  reg  [7:0]      rights_arg_reg;
  reg  [7:0]      sel_reg;
  reg  [63:0]     name_reg;
  reg  [7:0]      rights_reg [0:MAX_FILES-1];
  reg  [15:0]     used_reg;
  reg             we_reg;
  reg  [AW-1:0]   waddr_reg;
  wire [63:0]     slot_name;
  wire [9:0]      resource_identifier;
  wire [14:0]     offset;
  wire [1:0]      opcode;

  assign resource_identifier    = {resource_select_high[1:0], resource_select_low};
  assign offset = {operation_offset_high[6:0], operation_offset_low};
  assign opcode = offset[`UFM_OP_HI:`UFM_OP_LO];

  // ========================================================================
  // Name check: printable prefix of at least one byte, then zero padding
  function name_ok;
    input [63:0] n;
    integer i;
    reg     ended;
    reg     ok;
    reg [7:0] c;
    begin
      ended = 1'b0;
      ok = (n[7:0] != `UFM_CHR_NUL);
      for (i = 0; i < 8; i = i + 1)
      begin
        c = n[i*8 +: 8];
        if (c == `UFM_CHR_NUL)
          ended = 1'b1;
        else if (ended || c < `UFM_CHR_LO || c > `UFM_CHR_HI)
          ok = 1'b0;
      end
      name_ok = ok;
    end
  endfunction

  // A file is visible if either right is granted at the current level
  function visible;
    input [7:0] r;
    input [3:0] lvl;
    begin
      visible = (r[`UFM_RD_HI:`UFM_RD_LO] != `UFM_LVL_FORBID &&
                 lvl >= r[`UFM_RD_HI:`UFM_RD_LO]) ||
                (r[`UFM_WR_HI:`UFM_WR_LO] != `UFM_LVL_FORBID &&
                 lvl >= r[`UFM_WR_HI:`UFM_WR_LO]);
    end
  endfunction

  // Descriptor value for a resource, one byte except the 64-bit name
  function [63:0] descr;
    input       dir;
    input [7:0] sel;
    begin
      case (sel)
        `UFM_DSC_NAME:  descr = RES_NAME;
        `UFM_DSC_SIZE:  descr = {56'h0, `UFM_DATA_SIZE};
        `UFM_DSC_RDLVL: descr = {56'h0, dir ? `UFM_DIR_RDLVL : `UFM_MAINT_RDLVL};
        `UFM_DSC_WRLVL: descr = {56'h0, dir ? `UFM_DIR_WRLVL : `UFM_MAINT_WRLVL};
        `UFM_DSC_TMO:   descr = {56'h0, TMO_VALUE};
        `UFM_DSC_TYPE:  descr = {56'h0, dir ? `UFM_DIR_TYPE : `UFM_MAINT_TYPE};
        default:        descr = 64'h0;
      endcase
    end
  endfunction

  // ========================================================================
  // Name store; read address follows the scan index
  ufm_name_mem #(
    .DEPTH (MAX_FILES),
    .AW    (AW)
  ) u_names (
    .clk     (clk),
    .wr_en   (we_reg),
    .wr_addr (waddr_reg),
    .wr_data (name_reg),
    .rd_addr (idx_reg),
    .rd_data (slot_name)
  );

  // Close a transaction with an answer
  task finish;
    input [7:0]  code;
    input [63:0] data;
    begin
      parameter_access_done <= 1'b1;
      busy                  <= 1'b0;
      error_flag            <= (code != `UFM_ERR_NONE);
      error_code            <= code;
      reply_bytes           <= data;
      state_reg             <= S_IDLE;
    end
  endtask

  integer k;

  // ========================================================================
  // Command sequencer; one request at a time, triggers while busy ignored
  always @(posedge clk)
  begin
    if (rst)
    begin
      state_reg             <= S_IDLE;
      idx_reg               <= {AW{1'b0}};
      free_reg              <= {AW{1'b0}};
      free_found_reg        <= 1'b0;
      hits_reg              <= 8'h00;
      op_reg                <= `UFM_OP_DELETE;
      dir_reg               <= 1'b0;
      rights_arg_reg        <= 8'h00;
      sel_reg               <= 8'h00;
      name_reg              <= 64'h0;
      used_reg              <= 16'h0000;
      we_reg                <= 1'b0;
      waddr_reg             <= {AW{1'b0}};
      parameter_access_done <= 1'b0;
      busy                  <= 1'b0;
      error_flag            <= 1'b0;
      error_code            <= `UFM_ERR_NONE;
      reply_bytes           <= 64'h0;
      file_deleted          <= 1'b0;
      file_valid            <= {MAX_FILES{1'b0}};
      file_count            <= 8'h00;
      for (k = 0; k < MAX_FILES; k = k + 1)
        rights_reg[k] <= 8'h00;
    end
    else
    begin
      parameter_access_done <= 1'b0;
      file_deleted          <= 1'b0;
      we_reg                <= 1'b0;
      case (state_reg)
        S_IDLE:
        begin
          if (parameter_transaction_trigger)
          begin
            busy           <= 1'b1;
            op_reg         <= opcode;
            rights_arg_reg <= offset[`UFM_WR_HI:`UFM_RD_LO];
            sel_reg        <= offset[`UFM_SEL_HI:`UFM_SEL_LO];
            name_reg       <= long_message_bytes;
            free_found_reg <= 1'b0;
            hits_reg       <= 8'h00;
            idx_reg        <= {AW{1'b0}};
            dir_reg        <= (resource_identifier == `UFM_RID_DIR);
            if (resource_identifier != `UFM_RID_MAINT && resource_identifier != `UFM_RID_DIR)
              finish(`UFM_ERR_RID, 64'h0);
            else if (descriptor_read)
              finish(`UFM_ERR_NONE,
                     descr(resource_identifier == `UFM_RID_DIR, operation_offset_low));
            else if (resource_identifier == `UFM_RID_MAINT)
            begin
              if (!write_access)
                finish(`UFM_ERR_ACCESS, 64'h0);
              else if (opcode == `UFM_OP_CREATE)
              begin
                if (!name_ok(long_message_bytes))
                  finish(`UFM_ERR_NAME, 64'h0);
                else if (file_count == MAX_FILES ||
                         used_reg + HDR_BYTES > STORE_BYTES)
                  finish(`UFM_ERR_FULL, 64'h0);
                else
                  state_reg <= S_RD;
              end
              else if (opcode == `UFM_OP_CHANGE || opcode == `UFM_OP_DELETE)
              begin
                if (!file_loaded || !file_valid[loaded_slot])
                  finish(`UFM_ERR_NOT_LOADED, 64'h0);
                else if (opcode == `UFM_OP_DELETE)
                begin
                  file_valid[loaded_slot] <= 1'b0;
                  file_count   <= file_count - 8'h01;
                  used_reg     <= used_reg - HDR_BYTES;
                  file_deleted <= 1'b1;
                  finish(`UFM_ERR_NONE, 64'h0);
                end
                else
                begin
                  idx_reg   <= loaded_slot;
                  state_reg <= S_RD;
                end
              end
              else
                finish(`UFM_ERR_OPCODE, 64'h0);
            end
            else if (write_access)
              finish(`UFM_ERR_ACCESS, 64'h0);
            else if (operation_offset_low == `UFM_DIR_SUMMARY)
              finish(`UFM_ERR_NONE, {16'h0, used_reg,
                     STORE_BYTES - used_reg, 8'h00, file_count});
            else
              state_reg <= S_RD;
          end
        end
        // Read address presented, name arrives next cycle
        S_RD:
        begin
          state_reg <= S_CMP;
        end
        S_CMP:
        begin
          state_reg <= S_RD;
          idx_reg   <= idx_reg + 1'b1;
          if (dir_reg)
          begin
            if (file_valid[idx_reg] && visible(rights_reg[idx_reg], access_level))
            begin
              hits_reg <= hits_reg + 8'h01;
              if (hits_reg + 8'h01 == sel_reg)
                finish(`UFM_ERR_NONE, slot_name);
              else if (idx_reg == LAST_SLOT)
                finish(`UFM_ERR_NOT_FOUND, 64'h0);
            end
            else if (idx_reg == LAST_SLOT)
              finish(`UFM_ERR_NOT_FOUND, 64'h0);
          end
          else if (op_reg == `UFM_OP_CHANGE)
          begin
            if (slot_name == name_reg)
            begin
              rights_reg[idx_reg] <= rights_arg_reg;
              finish(`UFM_ERR_NONE, 64'h0);
            end
            else
              finish(`UFM_ERR_MISMATCH, 64'h0);
          end
          else if (file_valid[idx_reg] && slot_name == name_reg)
            finish(`UFM_ERR_EXISTS, 64'h0);
          else
          begin
            if (!file_valid[idx_reg] && !free_found_reg)
            begin
              free_reg       <= idx_reg;
              free_found_reg <= 1'b1;
            end
            if (idx_reg == LAST_SLOT)
            begin
              // Commit only after every slot was checked for a duplicate
              we_reg    <= 1'b1;
              waddr_reg <= free_found_reg ? free_reg : idx_reg;
              file_valid[free_found_reg ? free_reg : idx_reg] <= 1'b1;
              rights_reg[free_found_reg ? free_reg : idx_reg] <= rights_arg_reg;
              file_count <= file_count + 8'h01;
              used_reg   <= used_reg + HDR_BYTES;
              finish(`UFM_ERR_NONE, 64'h0);
            end
          end
        end
        default:
        begin
          finish(`UFM_ERR_NONE, 64'h0);
        end
      endcase
    end
  end

endmodule // ufm_file_manager

`default_nettype wire

// File: ufm_chk.sv
// Port assertions for the user file manager
`timescale 1ns/1ps
`default_nettype none
`include "ufm_defs.vh"
module ufm_chk #(
  parameter MAX_FILES = 16
) (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 rst,
  // Request
  input wire logic                 parameter_transaction_trigger,
  input wire logic                 write_access,
  input wire logic                 descriptor_read,
  input wire logic [7:0]           resource_select_high,
  input wire logic [7:0]           resource_select_low,
  input wire logic [7:0]           operation_offset_high,
  input wire logic [7:0]           operation_offset_low,
  input wire logic                 file_loaded,
  // Answer
  input wire logic                 parameter_access_done,
  input wire logic                 busy,
  input wire logic                 error_flag,
  input wire logic [7:0]           error_code,
  input wire logic [63:0]          reply_bytes,
  input wire logic                 file_deleted,
  input wire logic [MAX_FILES-1:0] file_valid,
  input wire logic [7:0]           file_count
);
  // ====
  // Decoded request, valid only on a taking edge
  wire       take = parameter_transaction_trigger & ~busy;
  wire [9:0] resource_identifier  = {resource_select_high[1:0], resource_select_low};
  wire       rd_q = take & ~write_access & ~descriptor_read;
  wire       wr_q = take & write_access & ~descriptor_read;
  wire       wr_m = wr_q & (resource_identifier == `UFM_RID_MAINT);
  wire [1:0] opc  = operation_offset_high[1:0];
  wire       done = parameter_access_done;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ====
  // Handshake and answers
  take_busy_a:
    assert property (take |=> busy ^ done) else $error("busy wrong after request");
  answer_bound_a:
    assert property (take |-> ##[1:40] done) else $error("answer missing");
  maint_read_a:
    assert property (rd_q && resource_identifier == `UFM_RID_MAINT |=> done && error_flag
      && error_code == `UFM_ERR_ACCESS) else $error("maintenance read not refused");
  dir_write_a:
    assert property (wr_q && resource_identifier == `UFM_RID_DIR |=> done && error_flag
      && error_code == `UFM_ERR_ACCESS) else $error("directory write not refused");
  bad_opcode_a:
    assert property (wr_m && opc == 2'h2 |=> done && error_code == `UFM_ERR_OPCODE)
      else $error("opcode 10b not refused");
  del_unloaded_a:
    assert property (wr_m && opc == `UFM_OP_DELETE && !file_loaded |=> done
      && error_code == `UFM_ERR_NOT_LOADED) else $error("delete without load");
  summary_a:
    assert property (rd_q && resource_identifier == `UFM_RID_DIR && operation_offset_low == 8'h00 |=> done
      && !error_flag && reply_bytes[63:48] == 16'h0000 && reply_bytes[15:8] == 8'h00
      && reply_bytes[7:0] == file_count) else $error("summary layout wrong");
  deleted_pulse_a:
    assert property (file_deleted |-> done && !error_flag
      && file_count == $past(file_count) - 8'h01) else $error("delete pulse wrong");
  count_hold_a:
    assert property ($changed(file_count) |-> done) else $error("count moved without answer");
  count_match_a:
    assert property (file_count == $countones(file_valid)) else $error("count and table differ");
  // Main scenarios seen
  cover property (wr_m && opc == `UFM_OP_CREATE ##33 done && !error_flag);
  cover property (file_deleted);
  cover property (rd_q && resource_identifier == `UFM_RID_DIR ##33 done && error_code == `UFM_ERR_NOT_FOUND);
endmodule // ufm_chk
bind ufm_file_manager ufm_chk #(.MAX_FILES(MAX_FILES)) chk_u (.clk, .rst,
  .parameter_transaction_trigger, .write_access, .descriptor_read, .resource_select_high,
  .resource_select_low, .operation_offset_high, .operation_offset_low, .file_loaded,
  .parameter_access_done, .busy, .error_flag, .error_code, .reply_bytes, .file_deleted,
  .file_valid, .file_count);
`default_nettype wire

// File: ufm_host.sv
// Drive-side master model issuing parameter transactions
`timescale 1ns/1ps
`default_nettype none
module ufm_host (
  // Clock and answer
  input wire logic    clk,
  input wire logic    parameter_access_done,
  // Request
  output logic        parameter_transaction_trigger,
  output logic        write_access,
  output logic        descriptor_read,
  output logic [7:0]  resource_select_high,
  output logic [7:0]  resource_select_low,
  output logic [7:0]  operation_offset_high,
  output logic [7:0]  operation_offset_low,
  output logic [63:0] long_message_bytes
);
  // ====
  // Idle lines from time zero
  initial
  begin
    {parameter_transaction_trigger, write_access, descriptor_read} = 3'h0;
    {resource_select_high, resource_select_low} = 16'h0000;
    {operation_offset_high, operation_offset_low} = 16'h0000;
    long_message_bytes = 64'h0;
  end
  // One transaction; fields hold until done, a poke retriggers while busy
  task automatic req(input logic w, d, input logic [9:0] resource_identifier, input logic [14:0] off,
                     input logic [63:0] bv, input logic poke, output int lat);
    @(negedge clk);
    {write_access, descriptor_read} = {w, d};
    {resource_select_high, resource_select_low} = {6'h00, resource_identifier};
    {operation_offset_high, operation_offset_low} = {1'b0, off};
    long_message_bytes = bv;
    parameter_transaction_trigger = 1'b1;
    lat = 0;
    while (lat >= 0)
    begin
      @(negedge clk);
      if (parameter_access_done === 1'b1)
        break;
      parameter_transaction_trigger = poke && lat == 3;
      lat++;
      if (lat > 60)
        lat = -1;
    end
    parameter_transaction_trigger = 1'b0;
  endtask
endmodule // ufm_host
`default_nettype wire

// File: ufm_tb.sv
// Self-checking bench for the user file manager
`timescale 1ns/1ps
`default_nettype none
`include "ufm_defs.vh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %s expected %0h seen %0h", n, e, g); end end
module testbench;
  // ====
  // Signals, reference table and counters
  logic        clk = 1'b0, rst = 1'b1, file_loaded = 1'b0;
  logic [3:0]  access_level = 4'h0, loaded_slot = 4'h0;
  wire         parameter_transaction_trigger, write_access, descriptor_read, busy;
  wire         parameter_access_done, error_flag, file_deleted;
  wire [7:0]   resource_select_high, resource_select_low, error_code, file_count;
  wire [7:0]   operation_offset_high, operation_offset_low;
  wire [63:0]  long_message_bytes, reply_bytes;
  wire [15:0]  file_valid;
  wire [99:0]  all_out = {parameter_access_done, busy, error_flag, file_deleted,
                          error_code, reply_bytes, file_valid, file_count};
  int          err_total = 0, comparisons = 0, lat;
  logic [63:0] mn[16];
  logic [3:0]  mr[16], mw[16];
  logic [15:0] mv = 16'h0000;
  logic [7:0]  dsel[4] = '{8'h01, 8'h02, 8'h03, 8'h05};
  logic [7:0]  dval[8] = '{8'h08, 8'h0F, 8'h00, 8'h0B, 8'h08, 8'h00, 8'h0F, 8'h18};
  always #5 clk = ~clk;
  ufm_file_manager dut_u (.clk, .rst, .parameter_transaction_trigger, .write_access,
    .descriptor_read, .resource_select_high, .resource_select_low, .operation_offset_high,
    .operation_offset_low, .long_message_bytes, .access_level, .file_loaded, .loaded_slot,
    .parameter_access_done, .busy, .error_flag, .error_code, .reply_bytes, .file_deleted,
    .file_valid, .file_count);
  ufm_host host_u (.clk, .parameter_access_done, .parameter_transaction_trigger,
    .write_access, .descriptor_read, .resource_select_high, .resource_select_low,
    .operation_offset_high, .operation_offset_low, .long_message_bytes);
  // ====
  // Reference model helpers
  function automatic bit vis(int i);
    return mv[i] && ((mr[i] != 4'hF && mr[i] <= access_level)
                  || (mw[i] != 4'hF && mw[i] <= access_level));
  endfunction
  function automatic bit nm_ok(logic [63:0] n);
    bit z = 0;
    if (n[7:0] == 8'h00)
      return 0;
    for (int k = 0; k < 8; k++)
      if (n[8*k+:8] == 8'h00)
        z = 1;
      else if (z || n[8*k+:8] < 8'h20 || n[8*k+:8] > 8'h7E)
        return 0;
    return 1;
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // One transaction, then answer code and file table against the model
  task automatic op(input logic w, d, input logic [9:0] resource_identifier, input logic [14:0] off,
                    input logic [63:0] n, input logic [7:0] c, input logic poke = 0);
    host_u.req(w, d, resource_identifier, off, n, poke, lat);
    if (lat < 0)
    begin
      err_total++;
      close_out();
    end
    else
    begin
      `CHK("error_code", c, error_code)
      `CHK("error_flag", c != 8'h00, error_flag)
      `CHK("file_count", 8'($countones(mv)), file_count)
      `CHK("file_valid", mv, file_valid)
    end
  endtask
  task automatic mk(input logic [63:0] n, input logic [3:0] wr, rd, input logic poke = 0);
    int s = -1;
    logic [7:0] c = 8'h00;
    for (int i = 15; i >= 0; i--)
      if (!mv[i])
        s = i;
    for (int i = 0; i < 16; i++)
      if (mv[i] && mn[i] == n)
        c = `UFM_ERR_EXISTS;
    if (!nm_ok(n))
      c = `UFM_ERR_NAME;
    else if (s < 0)
      c = `UFM_ERR_FULL;
    if (c == 0)
      {mv[s], mn[s], mw[s], mr[s]} = {1'b1, n, wr, rd};
    op(1, 0, 10'h133, {5'h15, 2'b11, wr, rd}, n, c, poke);
    if (c == 0)
      `CHK("create latency", 1 + 2 * 16, lat + 1)
  endtask
  task automatic rd_dir(input logic [7:0] n);
    int k = 0;
    logic [63:0] e = 64'h0;
    logic [7:0] c = `UFM_ERR_NOT_FOUND;
    logic [15:0] f = 16'($countones(mv)) * 16'h0010;
    if (n == 8'h00)
    begin
      c = 8'h00;
      e = {16'h0000, f, 16'h2000 - f, 8'h00, 8'($countones(mv))};
    end
    for (int i = 0; i < 16; i++)
      if (vis(i) && ++k == n)
        {c, e} = {8'h00, mn[i]};
    op(0, 0, 10'h134, {7'h55, n}, 64'h0, c);
    if (c == 0)
      `CHK("reply", e, reply_bytes)
  endtask
  task automatic chg(input logic [63:0] n, input logic [3:0] wr, rd);
    logic [7:0] c = !file_loaded ? 8'h07 : n != mn[loaded_slot] ? 8'h08 : 8'h00;
    if (c == 0)
      {mw[loaded_slot], mr[loaded_slot]} = {wr, rd};
    op(1, 0, 10'h133, {7'h01, wr, rd}, n, c);
  endtask
  task automatic del();
    logic [7:0] c = file_loaded ? 8'h00 : `UFM_ERR_NOT_LOADED;
    if (c == 0)
      mv[loaded_slot] = 1'b0;
    op(1, 0, 10'h133, 15'h00A5, 64'h0, c);
    `CHK("file_deleted", c == 0, file_deleted)
  endtask
  // ====
  // Test sequence
  initial
  begin
    void'($urandom(32'h8a52a88a));
    repeat (12) @(negedge clk);
    `CHK("reset outputs", 100'h0, all_out)
    rst = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      op(0, 1, i < 4 ? 10'h133 : 10'h134, {7'h00, dsel[i % 4]}, 64'h0, 8'h00);
      `CHK("descriptor", dval[i], reply_bytes[7:0])
    end
    op(0, 0, 10'h133, 15'h0000, 64'h0, `UFM_ERR_ACCESS);
    op(1, 0, 10'h134, 15'h0000, 64'h41, `UFM_ERR_ACCESS);
    op(0, 0, 10'h135, 15'h0000, 64'h0, `UFM_ERR_RID);
    op(1, 0, 10'h133, 15'h0200, 64'h41, `UFM_ERR_OPCODE);
    $display("test descriptors and refusals finished");
    mk(64'h31454C4946, 4'h1, 4'h0, 1'b1);
    mk(64'h31454C4946, 4'h2, 4'h2);
    mk(64'h0, 4'h0, 4'h0);
    mk(64'h7F41, 4'h0, 4'h0);
    mk(64'h1F, 4'h0, 4'h0);
    mk(64'h420041, 4'h0, 4'h0);
    mk(64'h207E, 4'h0, 4'h3);
    $display("test create finished");
    for (int n = 0; n < 4; n++)
      rd_dir(n[7:0]);
    mk(64'h4E444948, 4'hF, 4'h2);
    rd_dir(8'h03);
    access_level = 4'h2;
    rd_dir(8'h03);
    access_level = 4'h0;
    $display("test directory finished");
    chg(64'h31454C4946, 4'h0, 4'h0);
    file_loaded = 1'b1;
    chg(64'h207E, 4'h0, 4'h0);
    chg(64'h31454C4946, 4'hF, 4'hF);
    loaded_slot = 4'h1;
    chg(64'h207E, 4'h0, 4'h0);
    loaded_slot = 4'h0;
    rd_dir(8'h01);
    file_loaded = 1'b0;
    del();
    file_loaded = 1'b1;
    del();
    file_loaded = 1'b0;
    $display("test change and delete finished");
    access_level = 4'h4;
    while ($countones(mv) < 16)
      mk({48'h0, 8'($urandom_range(8'h7E, 8'h21)), 8'($urandom_range(8'h7E, 8'h20))},
         4'($urandom_range(4)), 4'($urandom_range(4)));
    mk(64'h5A, 4'h0, 4'h0);
    rd_dir(8'h00);
    rd_dir(8'h10);
    rd_dir(8'h11);
    $display("test full table finished");
    close_out();
  end
endmodule // testbench
`default_nettype wire
